// [hdl/call_and_clear_instruction_exec.sv]
`timescale 1ns/1ps
`default_nettype none
module call_and_clear_instruction_exec
   import exec_unit_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // Decoded instruction from fetch
   input wire logic op_valid_in,
   input wire op_t op_in,
   input wire logic [PC_W-1:0] op_target_in,
   input wire logic [ADDR_W-1:0] op_addr_in,
   input wire logic [BIT_W-1:0] op_bit_in,
   // Current contents of the addressed data memory byte
   input wire logic [DATA_W-1:0] mem_rdata_in,
   // Flag set events from watchdog and halt logic
   input wire logic timeout_set_in,
   input wire logic power_down_set_in,
   // Program counter and return stack
   output logic [PC_W-1:0] pc_out,
   output logic busy_out,
   output logic stack_push_out,
   output logic [PC_W-1:0] stack_data_out,
   // Data memory write port
   output logic mem_we_out,
   output logic [ADDR_W-1:0] mem_addr_out,
   output logic [DATA_W-1:0] mem_wdata_out,
   // Watchdog control and status flags
   output logic wdt_clear_out,
   output logic timeout_flag_out,
   output logic power_down_flag_out
);

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic [PC_W-1:0] pc_plus_one(input logic [PC_W-1:0] pc);
      pc_plus_one = pc + PC_STEP;
   endfunction

   logic accepted;
   logic [PC_W-1:0] call_target;
   preclear_mark_t marker;
   logic clear_now;

   logic [PC_W-1:0] next_pc;
   logic next_busy;
   logic [PC_W-1:0] next_call_target;
   logic next_stack_push;
   logic [PC_W-1:0] next_stack_data;
   logic next_mem_we;
   logic [ADDR_W-1:0] next_mem_addr;
   logic [DATA_W-1:0] next_mem_wdata;
   preclear_mark_t next_marker;
   logic next_wdt_clear;
   logic next_timeout;
   logic next_power_down;

   // New instructions are held off while a call finishes
   assign accepted = op_valid_in && !busy_out;

   // -----------------------------------------------------------------
   // Program counter and call sequencing
   // -----------------------------------------------------------------
   // Call pushes in its first cycle and jumps in its second
   always_comb begin
      next_pc = pc_out;
      next_busy = 1'b0;
      next_call_target = call_target;
      next_stack_push = 1'b0;
      next_stack_data = stack_data_out;
      if (busy_out) begin
         next_pc = call_target;
      end else if (accepted) begin
         if (op_in == OP_CALL) begin
            next_stack_push = 1'b1;
            next_stack_data = pc_plus_one(pc_out);
            next_call_target = op_target_in;
            next_busy = 1'b1;
         end else begin
            next_pc = pc_plus_one(pc_out);
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         pc_out <= PC_RESET;
         busy_out <= 1'b0;
         call_target <= PC_RESET;
         stack_push_out <= 1'b0;
         stack_data_out <= PC_RESET;
      end else begin
         pc_out <= next_pc;
         busy_out <= next_busy;
         call_target <= next_call_target;
         stack_push_out <= next_stack_push;
         stack_data_out <= next_stack_data;
      end
   end

   // -----------------------------------------------------------------
   // Data memory clears
   // -----------------------------------------------------------------
   // Bit clear is read-modify-write on the byte already presented
   always_comb begin
      next_mem_we = 1'b0;
      next_mem_addr = mem_addr_out;
      next_mem_wdata = mem_wdata_out;
      if (accepted && op_in == OP_CLR_BYTE) begin
         next_mem_we = 1'b1;
         next_mem_addr = op_addr_in;
         next_mem_wdata = DATA_ZERO;
      end else if (accepted && op_in == OP_CLR_BIT) begin
         next_mem_we = 1'b1;
         next_mem_addr = op_addr_in;
         next_mem_wdata = mem_rdata_in & ~(BIT_ONE << op_bit_in);
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         mem_we_out <= 1'b0;
         mem_addr_out <= ADDR_RESET;
         mem_wdata_out <= DATA_ZERO;
      end else begin
         mem_we_out <= next_mem_we;
         mem_addr_out <= next_mem_addr;
         mem_wdata_out <= next_mem_wdata;
      end
   end

   // -----------------------------------------------------------------
   // Watchdog clears and status flags
   // -----------------------------------------------------------------
   // Pair only counts when the opposite pre-clear follows; a
   // completed pair rearms the marker so a fresh pair is needed
   always_comb begin
      clear_now = 1'b0;
      next_marker = marker;
      if (accepted) begin
         case (op_in)
            OP_WATCHDOG_CLEAR: begin
               clear_now = 1'b1;
            end
            OP_FIRST_PRECLEAR: begin
               if (marker == MARK_SECOND) begin
                  clear_now = 1'b1;
                  next_marker = MARK_NONE;
               end else begin
                  next_marker = MARK_FIRST;
               end
            end
            OP_SECOND_PRECLEAR: begin
               if (marker == MARK_FIRST) begin
                  clear_now = 1'b1;
                  next_marker = MARK_NONE;
               end else begin
                  next_marker = MARK_SECOND;
               end
            end
            default: begin
               next_marker = marker;
            end
         endcase
      end
      next_wdt_clear = clear_now;
      // A set event in the clearing cycle wins, so it is not lost
      next_timeout = timeout_set_in ? 1'b1 : (clear_now ? 1'b0 : timeout_flag_out);
      next_power_down = power_down_set_in ? 1'b1 : (clear_now ? 1'b0 : power_down_flag_out);
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         marker <= MARK_NONE;
         wdt_clear_out <= 1'b0;
         timeout_flag_out <= FLAG_RESET;
         power_down_flag_out <= FLAG_RESET;
      end else begin
         marker <= next_marker;
         wdt_clear_out <= next_wdt_clear;
         timeout_flag_out <= next_timeout;
         power_down_flag_out <= next_power_down;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   property p_call_push;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (accepted && op_in == OP_CALL) |=> stack_push_out && stack_data_out == pc_out + PC_STEP;
   endproperty
   a_call_push: assert property (p_call_push) else $error("call did not push next address");

   property p_call_load;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (accepted && op_in == OP_CALL) |-> ##2 pc_out == $past(op_target_in, 2) && !stack_push_out;
   endproperty
   a_call_load: assert property (p_call_load) else $error("call did not load its target");

   property p_call_two_cycles;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (accepted && op_in == OP_CALL) |=> busy_out ##1 !busy_out;
   endproperty
   a_call_two_cycles: assert property (p_call_two_cycles) else $error("call not two cycles");

   property p_byte_clear;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (accepted && op_in == OP_CLR_BYTE) |=>
         mem_we_out && mem_wdata_out == DATA_ZERO && mem_addr_out == $past(op_addr_in);
   endproperty
   a_byte_clear: assert property (p_byte_clear) else $error("byte clear wrote wrong data");

   property p_bit_clear;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (accepted && op_in == OP_CLR_BIT) |=>
         mem_we_out && mem_wdata_out == ($past(mem_rdata_in) & ~(BIT_ONE << $past(op_bit_in)));
   endproperty
   a_bit_clear: assert property (p_bit_clear) else $error("bit clear touched wrong bits");

   property p_watchdog_clear;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (accepted && op_in == OP_WATCHDOG_CLEAR && !timeout_set_in && !power_down_set_in) |=>
         wdt_clear_out && !timeout_flag_out && !power_down_flag_out;
   endproperty
   a_watchdog_clear: assert property (p_watchdog_clear) else $error("watchdog clear failed");

   property p_first_after_second;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (accepted && op_in == OP_FIRST_PRECLEAR && marker == MARK_SECOND) |=> wdt_clear_out;
   endproperty
   a_first_after_second: assert property (p_first_after_second) else $error("pair did not clear");

   property p_second_after_first;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (accepted && op_in == OP_SECOND_PRECLEAR && marker == MARK_FIRST) |=> wdt_clear_out;
   endproperty
   a_second_after_first: assert property (p_second_after_first) else $error("pair did not clear");

   property p_first_repeat;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (accepted && op_in == OP_FIRST_PRECLEAR && marker != MARK_SECOND) |=> !wdt_clear_out;
   endproperty
   a_first_repeat: assert property (p_first_repeat) else $error("lone first pre-clear acted");

   property p_second_repeat;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (accepted && op_in == OP_SECOND_PRECLEAR && marker != MARK_FIRST) |=> !wdt_clear_out;
   endproperty
   a_second_repeat: assert property (p_second_repeat) else $error("lone second pre-clear acted");

   property p_flags_hold;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (!clear_now && !timeout_set_in && !power_down_set_in) |=>
         $stable(timeout_flag_out) && $stable(power_down_flag_out) && !wdt_clear_out;
   endproperty
   a_flags_hold: assert property (p_flags_hold) else $error("flags changed without a clear");

   property p_marker_reset;
      @(posedge core_clk_in)
      !reset_n_in |=> marker == MARK_NONE;
   endproperty
   a_marker_reset: assert property (p_marker_reset) else $error("marker not reset");

endmodule
`default_nettype wire

// [shared/exec_unit_pkg.sv]
`default_nettype none
package exec_unit_pkg;
   // -----------------------------------------------------------------
   // Widths of the datapaths
   // -----------------------------------------------------------------
   localparam int PC_W = 11;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int BIT_W = 3;

   // -----------------------------------------------------------------
   // Values after reset and fixed constants
   // -----------------------------------------------------------------
   localparam logic [PC_W-1:0] PC_RESET = 11'h000;
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
   localparam logic [DATA_W-1:0] BIT_ONE = 8'h01;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;
   localparam logic [PC_W-1:0] PC_STEP = 11'h001;
   localparam logic FLAG_RESET = 1'b0;
   // Cycles taken by a subroutine call
   localparam int CALL_CYCLES = 2;

   // -----------------------------------------------------------------
   // Decoded operations handed over by the fetch stage
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_OTHER,
      OP_CALL,
      OP_CLR_BYTE,
      OP_CLR_BIT,
      OP_WATCHDOG_CLEAR,
      OP_FIRST_PRECLEAR,
      OP_SECOND_PRECLEAR
   } op_t;

   // Which unpaired pre-clear instruction ran last
   typedef enum logic [1:0] {
      MARK_NONE,
      MARK_FIRST,
      MARK_SECOND
   } preclear_mark_t;
endpackage
`default_nettype wire

// [testbench/tb_call_and_clear_instruction_exec.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_call_and_clear_instruction_exec;
   import exec_unit_pkg::*;
   logic core_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic op_valid_in = 1'b0;
   op_t op_in = OP_OTHER;
   logic [PC_W-1:0] op_target_in = 11'h000;
   logic [ADDR_W-1:0] op_addr_in = 7'h00;
   logic [BIT_W-1:0] op_bit_in = 3'h0;
   logic [DATA_W-1:0] mem_rdata_in = 8'h00;
   logic timeout_set_in = 1'b0;
   logic power_down_set_in = 1'b0;
   logic [PC_W-1:0] pc_out, stack_data_out, exp_pc, t;
   logic busy_out, stack_push_out, mem_we_out, wdt_clear_out, timeout_flag_out, power_down_flag_out;
   logic [ADDR_W-1:0] mem_addr_out, a;
   logic [DATA_W-1:0] mem_wdata_out, d;
   logic [PC_W-1:0] push_q[$];
   logic [ADDR_W+DATA_W-1:0] mem_q[$];
   int clr_pending = 0;
   int fail_count = 0;
   int samples_checked = 0;
   integer seed = 32'h09ee_8dc7;

   call_and_clear_instruction_exec call_and_clear_instruction_exec_inst (.core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in), .op_valid_in(op_valid_in), .op_in(op_in), .op_target_in(op_target_in),
      .op_addr_in(op_addr_in), .op_bit_in(op_bit_in), .mem_rdata_in(mem_rdata_in),
      .timeout_set_in(timeout_set_in), .power_down_set_in(power_down_set_in), .pc_out(pc_out),
      .busy_out(busy_out), .stack_push_out(stack_push_out), .stack_data_out(stack_data_out),
      .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
      .wdt_clear_out(wdt_clear_out), .timeout_flag_out(timeout_flag_out),
      .power_down_flag_out(power_down_flag_out));

   // ----------------------------------------
   // Clock, compare and closing tasks
   // ----------------------------------------
   always #2.5 core_clk_in = ~core_clk_in;

   task automatic compare_value(input logic [15:0] got, input logic [15:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // A pulse with no note waiting is always a fault
   task automatic compare_event(input string what);
      samples_checked++;
      fail_count++;
      $display("[ERR] %0t unexpected %s", $time, what);
   endtask

   task automatic stop_test;
      $display("samples_checked %0d fail_count %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Drivers on the rising edge, flag check on the falling edge
   // ----------------------------------------
   task automatic issue(input op_t op, input logic [PC_W-1:0] tg, input logic [ADDR_W-1:0] ad,
                        input logic [BIT_W-1:0] bi, input logic [DATA_W-1:0] rd);
      @(posedge core_clk_in);
      op_valid_in <= 1'b1;
      op_in <= op;
      op_target_in <= tg;
      op_addr_in <= ad;
      op_bit_in <= bi;
      mem_rdata_in <= rd;
   endtask

   task automatic idle(input int n);
      repeat (n) begin
         @(posedge core_clk_in);
         op_valid_in <= 1'b0;
         mem_rdata_in <= 8'(~mem_rdata_in);
      end
   endtask

   // Set lands one edge after the strobe, so look a half cycle later;
   // also ends a held instruction so it is not taken again
   task automatic set_flags;
      @(posedge core_clk_in);
      op_valid_in <= 1'b0;
      timeout_set_in <= 1'b1;
      power_down_set_in <= 1'b1;
      @(posedge core_clk_in);
      timeout_set_in <= 1'b0;
      power_down_set_in <= 1'b0;
   endtask

   task automatic check_flags(input logic [1:0] exp);
      @(negedge core_clk_in);
      compare_value({timeout_flag_out, power_down_flag_out}, exp, "flags");
   endtask

   // ----------------------------------------
   // Output watcher, drains the notes in order
   // ----------------------------------------
   always @(negedge core_clk_in) begin
      if (reset_n_in) begin
         if (stack_push_out === 1'b1) begin
            if (push_q.size() == 0) compare_event("push");
            else compare_value(stack_data_out, push_q.pop_front(), "push");
            compare_value(busy_out, 1'b1, "busy");
         end
         if (mem_we_out === 1'b1) begin
            if (mem_q.size() == 0) compare_event("write");
            else compare_value({mem_addr_out, mem_wdata_out}, mem_q.pop_front(), "write");
         end
         if (wdt_clear_out === 1'b1) begin
            if (clr_pending == 0) compare_event("clear");
            else clr_pending--;
            compare_value({timeout_flag_out, power_down_flag_out}, 2'b00, "clear flags");
         end
      end
   end

   initial begin
      #(5 * 20000);
      fail_count++;
      stop_test();
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      exp_pc = PC_RESET;
      repeat (16) @(posedge core_clk_in);
      reset_n_in <= 1'b1;
      // Back-to-back bit and byte clears, every bit position
      for (int i = 0; i < 8; i++) begin
         a = 7'($random(seed));
         d = 8'($random(seed));
         issue(OP_CLR_BIT, 11'h000, a, 3'(i), d);
         mem_q.push_back({a, d & ~(8'h01 << i)});
         a = 7'($random(seed));
         issue(OP_CLR_BYTE, 11'h000, a, 3'(i), 8'hff);
         mem_q.push_back({a, DATA_ZERO});
         exp_pc = exp_pc + 11'h002;
      end
      set_flags();
      // Calls with an instruction offered during the busy cycle
      repeat (3) begin
         t = 11'($random(seed));
         issue(OP_CALL, t, 7'h00, 3'h0, 8'h00);
         push_q.push_back(exp_pc + PC_STEP);
         issue(OP_CLR_BYTE, 11'h000, 7'h05, 3'h0, 8'hff);
         idle(1);
         check_flags(2'b11);
         compare_value(pc_out, t, "call target");
         exp_pc = t;
      end
      // Pre-clear alternation
      issue(OP_FIRST_PRECLEAR, 11'h000, 7'h00, 3'h0, 8'h00);
      issue(OP_FIRST_PRECLEAR, 11'h000, 7'h00, 3'h0, 8'h00);
      issue(OP_OTHER, 11'h000, 7'h00, 3'h0, 8'h00);
      idle(1);
      check_flags(2'b11);
      clr_pending++;
      issue(OP_SECOND_PRECLEAR, 11'h000, 7'h00, 3'h0, 8'h00);
      idle(2);
      set_flags();
      issue(OP_SECOND_PRECLEAR, 11'h000, 7'h00, 3'h0, 8'h00);
      issue(OP_SECOND_PRECLEAR, 11'h000, 7'h00, 3'h0, 8'h00);
      idle(1);
      check_flags(2'b11);
      clr_pending++;
      issue(OP_FIRST_PRECLEAR, 11'h000, 7'h00, 3'h0, 8'h00);
      idle(2);
      set_flags();
      issue(OP_SECOND_PRECLEAR, 11'h000, 7'h00, 3'h0, 8'h00);
      idle(1);
      check_flags(2'b11);
      clr_pending++;
      issue(OP_WATCHDOG_CLEAR, 11'h000, 7'h00, 3'h0, 8'h00);
      idle(2);
      compare_value(pc_out, exp_pc + 11'h009, "pc advance");
      // First pairs with the earlier second across the watchdog clear,
      // a lone first then arms the marker; reset in mid-run forgets it
      clr_pending++;
      issue(OP_FIRST_PRECLEAR, 11'h000, 7'h00, 3'h0, 8'h00);
      issue(OP_FIRST_PRECLEAR, 11'h000, 7'h00, 3'h0, 8'h00);
      idle(1);
      reset_n_in <= 1'b0;
      idle(2);
      reset_n_in <= 1'b1;
      check_flags(2'b00);
      compare_value(pc_out, PC_RESET, "pc after reset");
      set_flags();
      issue(OP_SECOND_PRECLEAR, 11'h000, 7'h00, 3'h0, 8'h00);
      idle(2);
      check_flags(2'b11);
      compare_value(push_q.size() + mem_q.size() + clr_pending, 16'h0000, "notes left");
      stop_test();
   end
endmodule
`default_nettype wire
